// [hdl/scbu_pkg.sv]
package scbu_pkg;

    // ------------------------------------------------------------------
    // Instruction fields (bit 31 is the first bit of the encoding)
    // ------------------------------------------------------------------
    localparam int unsigned XLEN      = 32;
    localparam int unsigned OPC_MSB   = 31;
    localparam int unsigned OPC_LSB   = 26;
    localparam int unsigned DSLOT_BIT = 25;
    localparam int unsigned COND_MSB  = 24;
    localparam int unsigned COND_LSB  = 21;
    localparam int unsigned IMM_MSB   = 15;
    localparam int unsigned IMM_W     = 16;

    localparam logic [5:0] OPC_REG_FORM = 6'h27;
    localparam logic [5:0] OPC_IMM_FORM = 6'h2f;
    localparam logic [3:0] COND_GT      = 4'h4;
    localparam logic [3:0] COND_LE      = 4'h3;
    localparam logic [3:0] COND_LT      = 4'h2;

    localparam logic [31:0] PC_STEP     = 32'h0000_0004;
    localparam logic [31:0] PC_RESET    = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Latencies in core clock cycles
    // ------------------------------------------------------------------
    localparam int unsigned CNT_W            = 4;
    localparam logic [3:0]  LAT_SHORT        = 4'h1;
    localparam logic [3:0]  LAT_TAKEN_SLOT   = 4'h2;
    localparam logic [3:0]  LAT_TAKEN_NOSLOT = 4'h3;
    localparam logic [3:0]  LAT_MISP_FAST    = 4'h3;
    localparam int unsigned LAT_MISP_MIN     = 7;
    localparam int unsigned LAT_MISP_MAX     = 9;
    localparam int unsigned LAT_MISP_DEF     = 8;
    localparam int unsigned AREA_LVL_SMALL   = 2;
    localparam int unsigned AREA_LVL_MAX     = 2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_SLOT = 2'b10
    } scbu_state_t;

endpackage

// [hdl/scbu_branch_unit.sv]
`timescale 1ns/100ps
`default_nettype none

module scbu_branch_unit #(
    parameter int unsigned AREA_OPT_LEVEL = 0,
    parameter int unsigned MISP_SMALL_LAT = scbu_pkg::LAT_MISP_DEF
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic        INSTR_VALID,
    input  wire logic [31:0] INSTR,
    input  wire logic [31:0] PC_CUR,
    input  wire logic [31:0] SOURCE_REG_A,
    input  wire logic [31:0] OFFSET_REG_B,
    input  wire logic        IMM_PREFIX_VALID,
    input  wire logic [15:0] IMM_PREFIX_HI,
    input  wire logic        PRED_VALID,
    input  wire logic        PRED_TAKEN,
    input  wire logic        SLOT_DONE,
    input  wire logic        INTR_REQ,
    input  wire logic        BRK_REQ,
    output logic             READY,
    output logic             DECODE_HIT,
    output logic             DONE,
    output logic             TAKEN,
    output logic [31:0]      NEXT_PC,
    output logic             SQUASH_NEXT,
    output logic             SLOT_ALLOW,
    output logic             EVENT_HOLD,
    output logic             INTR_ACK,
    output logic             BRK_ACK
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (AREA_OPT_LEVEL > scbu_pkg::AREA_LVL_MAX) begin : g_bad_area
        $error("AREA_OPT_LEVEL out of range");
    end
    if (MISP_SMALL_LAT < scbu_pkg::LAT_MISP_MIN ||
        MISP_SMALL_LAT > scbu_pkg::LAT_MISP_MAX) begin : g_bad_misp
        $error("MISP_SMALL_LAT must lie in 7..9");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        scbu_pkg::scbu_state_t       st;
        logic [scbu_pkg::CNT_W-1:0]  cnt;
        logic                        slot_d;
        logic                        ready;
        logic                        hit;
        logic                        done;
        logic                        taken;
        logic [31:0]                 npc;
        logic                        squash;
        logic                        slot_allow;
        logic                        hold;
        logic                        intr_ack;
        logic                        brk_ack;
    } scbu_regs_t;

    localparam logic [3:0] MISP_LAT =
        (AREA_OPT_LEVEL == scbu_pkg::AREA_LVL_SMALL) ?
        4'(MISP_SMALL_LAT) : scbu_pkg::LAT_MISP_FAST;

    scbu_regs_t q;
    scbu_regs_t d;

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    // Only the four compare-with-zero forms of this group are claimed;
    // every other encoding is left to the rest of the decoder.
    function automatic logic is_group(input logic [31:0] ins);
        logic [5:0] opc;
        logic [3:0] cnd;
        opc = ins[scbu_pkg::OPC_MSB:scbu_pkg::OPC_LSB];
        cnd = ins[scbu_pkg::COND_MSB:scbu_pkg::COND_LSB];
        is_group = 1'b0;
        if (opc == scbu_pkg::OPC_IMM_FORM) begin
            is_group = (cnd == scbu_pkg::COND_GT) ||
                       (cnd == scbu_pkg::COND_LE);
        end else if (opc == scbu_pkg::OPC_REG_FORM) begin
            is_group = (cnd == scbu_pkg::COND_LE) ||
                       (cnd == scbu_pkg::COND_LT);
        end
    endfunction

    function automatic logic cond_true(input logic [3:0]  cnd,
                                       input logic [31:0] a);
        logic neg;
        logic zero;
        neg  = a[31];
        zero = (a == 32'h0000_0000);
        cond_true = 1'b0;
        case (cnd)
            scbu_pkg::COND_GT: cond_true = !neg && !zero;
            scbu_pkg::COND_LE: cond_true = neg || zero;
            scbu_pkg::COND_LT: cond_true = neg;
            default:           cond_true = 1'b0;
        endcase
    endfunction

    // Closing step shared by the one-cycle path and the counted path
    function automatic scbu_regs_t finish(input scbu_regs_t r);
        scbu_regs_t f;
        f        = r;
        f.done   = 1'b1;
        f.squash = r.taken && !r.slot_d;
        if (r.slot_d) begin
            // Slot instruction runs before the target; no new branch
            // is accepted, so the slot cannot hold one
            f.st         = scbu_pkg::ST_SLOT;
            f.ready      = 1'b0;
            f.slot_allow = 1'b1;
        end else begin
            f.st    = scbu_pkg::ST_IDLE;
            f.ready = 1'b1;
            f.hold  = 1'b0;
        end
        finish = f;
    endfunction

    // ------------------------------------------------------------------
    // Operand and latency selection for the offered instruction
    // ------------------------------------------------------------------
    logic [3:0]  in_cond;
    logic        in_imm_form;
    logic        in_slot;
    logic        in_taken;
    logic [15:0] in_imm;
    logic [31:0] in_offset;
    logic [31:0] in_target;
    logic [3:0]  in_lat;

    always_comb begin
        in_cond     = INSTR[scbu_pkg::COND_MSB:scbu_pkg::COND_LSB];
        in_imm_form = INSTR[scbu_pkg::OPC_MSB:scbu_pkg::OPC_LSB] ==
                      scbu_pkg::OPC_IMM_FORM;
        in_slot     = INSTR[scbu_pkg::DSLOT_BIT];
        in_imm      = INSTR[scbu_pkg::IMM_MSB:0];
        in_taken    = cond_true(in_cond, SOURCE_REG_A);

        if (!in_imm_form) begin
            in_offset = OFFSET_REG_B;
        end else if (IMM_PREFIX_VALID) begin
            in_offset = {IMM_PREFIX_HI, in_imm};
        end else begin
            in_offset = {{scbu_pkg::IMM_W{in_imm[15]}}, in_imm};
        end

        if (in_taken) begin
            in_target = PC_CUR + in_offset;
        end else begin
            in_target = PC_CUR + scbu_pkg::PC_STEP;
        end

        // Prediction is consulted only for the immediate form
        if (in_imm_form && PRED_VALID) begin
            if (PRED_TAKEN == in_taken) begin
                in_lat = scbu_pkg::LAT_SHORT;
            end else begin
                in_lat = MISP_LAT;
            end
        end else if (!in_taken) begin
            in_lat = scbu_pkg::LAT_SHORT;
        end else if (in_slot) begin
            in_lat = scbu_pkg::LAT_TAKEN_SLOT;
        end else begin
            in_lat = scbu_pkg::LAT_TAKEN_NOSLOT;
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d        = q;
        d.done   = 1'b0;
        d.squash = 1'b0;
        case (q.st)
            scbu_pkg::ST_IDLE: begin
                d.ready = 1'b1;
                d.hit   = 1'b0;
                if (INSTR_VALID && q.ready && is_group(INSTR)) begin
                    d.hit    = 1'b1;
                    d.taken  = in_taken;
                    // The PC is the only architectural state touched
                    d.npc    = in_target;
                    d.slot_d = in_slot;
                    d.hold   = 1'b1;
                    if (in_lat == scbu_pkg::LAT_SHORT) begin
                        d = finish(d);
                    end else begin
                        d.cnt   = in_lat - 4'h1;
                        d.st    = scbu_pkg::ST_WAIT;
                        d.ready = 1'b0;
                    end
                end
            end
            scbu_pkg::ST_WAIT: begin
                d.cnt = q.cnt - 4'h1;
                if (q.cnt == 4'h1) begin
                    d = finish(d);
                end
            end
            scbu_pkg::ST_SLOT: begin
                // Events stay held until the slot instruction retires
                if (SLOT_DONE) begin
                    d.st         = scbu_pkg::ST_IDLE;
                    d.ready      = 1'b1;
                    d.slot_allow = 1'b0;
                    d.hold       = 1'b0;
                end
            end
            default: begin
                d.st    = scbu_pkg::ST_IDLE;
                d.ready = 1'b1;
            end
        endcase
        // Requests are levels: a held request is simply granted later
        d.intr_ack = INTR_REQ && !d.hold;
        d.brk_ack  = BRK_REQ && !d.hold;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            q.st         <= scbu_pkg::ST_IDLE;
            q.cnt        <= '0;
            q.slot_d     <= 1'b0;
            q.ready      <= 1'b0;
            q.hit        <= 1'b0;
            q.done       <= 1'b0;
            q.taken      <= 1'b0;
            q.npc        <= scbu_pkg::PC_RESET;
            q.squash     <= 1'b0;
            q.slot_allow <= 1'b0;
            q.hold       <= 1'b0;
            q.intr_ack   <= 1'b0;
            q.brk_ack    <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign READY       = q.ready;
    assign DECODE_HIT  = q.hit;
    assign DONE        = q.done;
    assign TAKEN       = q.taken;
    assign NEXT_PC     = q.npc;
    assign SQUASH_NEXT = q.squash;
    assign SLOT_ALLOW  = q.slot_allow;
    assign EVENT_HOLD  = q.hold;
    assign INTR_ACK    = q.intr_ack;
    assign BRK_ACK     = q.brk_ack;

endmodule

`default_nettype wire

// [dv/scbu_fetch_model.sv]
`timescale 1ns/100ps
`default_nettype none
module scbu_fetch_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       slot_allow,
    input  wire logic [3:0] slot_wait,
    output var  logic       slot_done
);
    logic [3:0] cnt;
    // Slot holds a plain instruction, never a prefix or branch
    always @(negedge clk) begin
        if (rst || !slot_allow || slot_done) begin
            slot_done <= 1'b0;
            cnt <= 4'h0;
        end else if (cnt == slot_wait) begin
            slot_done <= 1'b1;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

// [dv/scbu_branch_unit_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module scbu_branch_unit_sva (
    input wire logic        CORE_CLK,
    input wire logic        RST,
    input wire logic        INSTR_VALID,
    input wire logic [31:0] INSTR,
    input wire logic        PRED_VALID,
    input wire logic        READY,
    input wire logic        DECODE_HIT,
    input wire logic        DONE,
    input wire logic        TAKEN,
    input wire logic        SQUASH_NEXT,
    input wire logic        SLOT_ALLOW,
    input wire logic        SLOT_DONE,
    input wire logic        EVENT_HOLD,
    input wire logic        INTR_REQ,
    input wire logic        INTR_ACK
);
    wire logic [3:0] cnd = INSTR[24:21];
    wire logic imm_f = INSTR[31:26] == scbu_pkg::OPC_IMM_FORM &&
        (cnd == scbu_pkg::COND_GT || cnd == scbu_pkg::COND_LE);
    wire logic reg_f = INSTR[31:26] == scbu_pkg::OPC_REG_FORM &&
        (cnd == scbu_pkg::COND_LE || cnd == scbu_pkg::COND_LT);
    wire logic acc = INSTR_VALID && READY && (imm_f || reg_f);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);
    sequence s_reg;
        acc && reg_f;
    endsequence
    sequence s_reg_nd;
        acc && reg_f && !INSTR[25];
    endsequence
    // Prediction can shorten imm forms, so only fixed-latency cases
    sequence s_fix_d;
        acc && INSTR[25] && (reg_f || !PRED_VALID);
    endsequence
    sequence s_slot_end;
        SLOT_ALLOW && SLOT_DONE;
    endsequence
    sq_taken_a: assert property (SQUASH_NEXT |-> DONE && TAKEN)
        else $error("squash without taken branch");
    reg_short_a: assert property (s_reg ##1 !TAKEN |-> DONE)
        else $error("register branch not taken took too long");
    reg_three_a: assert property (s_reg_nd ##1 TAKEN |->
        !DONE ##1 !DONE ##1 DONE) else $error("taken reg latency");
    slot_two_a: assert property (s_fix_d ##1 TAKEN |->
        !DONE ##1 DONE) else $error("delayed taken latency");
    slot_ready_a: assert property (SLOT_ALLOW |-> !READY)
        else $error("ready while slot open");
    slot_end_a: assert property (s_slot_end |=>
        !SLOT_ALLOW && !EVENT_HOLD && READY) else $error("slot end");
    intr_defer_a: assert property (INTR_ACK |->
        !EVENT_HOLD && $past(INTR_REQ)) else $error("event not held");
    // Hold drops at once only for a one-cycle branch with no slot
    hit_flag_a: assert property (acc |=> DECODE_HIT &&
        (EVENT_HOLD != (DONE && !SLOT_ALLOW)))
        else $error("accepted branch not flagged");
endmodule
`default_nettype wire

// [dv/scbu_branch_unit_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module scbu_branch_unit_tb;
    logic        CORE_CLK, RST, INSTR_VALID, IMM_PREFIX_VALID;
    logic        PRED_VALID, PRED_TAKEN, SLOT_DONE, INTR_REQ, BRK_REQ;
    logic        READY, DECODE_HIT, DONE, TAKEN, SQUASH_NEXT;
    logic        SLOT_ALLOW, EVENT_HOLD, INTR_ACK, BRK_ACK;
    logic [31:0] INSTR, PC_CUR, SOURCE_REG_A, OFFSET_REG_B, NEXT_PC;
    logic [15:0] IMM_PREFIX_HI;
    logic [3:0]  slot_wait;
    logic        a2_done;
    int          errors, check_count;
    scbu_branch_unit u_dut (.*);
    // Second unit at area level two, watched only for its slow mispredict
    scbu_branch_unit #(.AREA_OPT_LEVEL(2)) u_dut2 (
        .CORE_CLK(CORE_CLK), .RST(RST), .INSTR_VALID(INSTR_VALID),
        .INSTR(INSTR), .PC_CUR(PC_CUR), .SOURCE_REG_A(SOURCE_REG_A),
        .OFFSET_REG_B(OFFSET_REG_B), .IMM_PREFIX_VALID(IMM_PREFIX_VALID),
        .IMM_PREFIX_HI(IMM_PREFIX_HI), .PRED_VALID(PRED_VALID),
        .PRED_TAKEN(PRED_TAKEN), .SLOT_DONE(SLOT_DONE),
        .INTR_REQ(INTR_REQ), .BRK_REQ(BRK_REQ), .READY(),
        .DECODE_HIT(), .DONE(a2_done), .TAKEN(), .NEXT_PC(),
        .SQUASH_NEXT(), .SLOT_ALLOW(), .EVENT_HOLD(), .INTR_ACK(),
        .BRK_ACK());
    scbu_fetch_model u_fetch (.clk(CORE_CLK), .rst(RST),
        .slot_allow(SLOT_ALLOW), .slot_wait(slot_wait),
        .slot_done(SLOT_DONE));
    initial begin
        CORE_CLK = 1'b0;
        forever #50 CORE_CLK = ~CORE_CLK;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] ei(logic d, logic [3:0] c,
                                       logic [15:0] i);
        return {scbu_pkg::OPC_IMM_FORM, d, c, 5'h03, i};
    endfunction
    function automatic logic [31:0] er(logic d, logic [3:0] c);
        return {scbu_pkg::OPC_REG_FORM, d, c, 5'h03, 16'h0000};
    endfunction
    task automatic run(input logic [31:0] ins, input logic [31:0] a,
        input int lat, input logic tk, input logic [31:0] npc);
        int n;
        n = 0;
        while (READY !== 1'b1 && n < 30) begin
            @(negedge CORE_CLK);
            n++;
        end
        INSTR = ins;
        SOURCE_REG_A = a;
        INSTR_VALID = 1'b1;
        @(negedge CORE_CLK);
        INSTR_VALID = 1'b0;
        chk(DECODE_HIT, 1'b1);
        n = 1;
        while (DONE !== 1'b1 && n < 20) begin
            @(negedge CORE_CLK);
            n++;
        end
        chk(32'(n), 32'(lat));
        chk(TAKEN, tk);
        chk(NEXT_PC, npc);
        chk(SQUASH_NEXT, tk && !ins[25]);
        @(negedge CORE_CLK);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_cond;
        run(ei(0, scbu_pkg::COND_GT, 16'hfff0), 1, 3, 1, 32'h0ff0);
        run(ei(0, scbu_pkg::COND_GT, 16'hfff0), 0, 1, 0, 32'h1004);
        run(ei(0, scbu_pkg::COND_GT, 16'h0), 32'h8000_0000, 1, 0, 32'h1004);
        run(ei(0, scbu_pkg::COND_LE, 16'h0010), 0, 3, 1, 32'h1010);
        run(ei(0, scbu_pkg::COND_LE, 16'h0), 1, 1, 0, 32'h1004);
        run(er(0, scbu_pkg::COND_LE), -1, 3, 1, 32'h1200);
        run(er(0, scbu_pkg::COND_LE), 1, 1, 0, 32'h1004);
        run(er(0, scbu_pkg::COND_LT), -1, 3, 1, 32'h1200);
        run(er(0, scbu_pkg::COND_LT), 0, 1, 0, 32'h1004);
    endtask
    task automatic t_slot;
        slot_wait = 4'h3;
        run(ei(1, scbu_pkg::COND_GT, 16'h0020), 5, 2, 1, 32'h1020);
        run(er(1, scbu_pkg::COND_LT), -1, 2, 1, 32'h1200);
        slot_wait = 4'h0;
        run(er(1, scbu_pkg::COND_LE), 1, 1, 0, 32'h1004);
        IMM_PREFIX_VALID = 1'b1;
        run(ei(0, scbu_pkg::COND_GT, 16'h8000), 1, 3, 1, 32'h1234_9000);
        IMM_PREFIX_VALID = 1'b0;
        run(ei(0, scbu_pkg::COND_GT, 16'h8000), 1, 3, 1, 32'hffff_9000);
    endtask
    task automatic t_pred;
        int k;
        PRED_VALID = 1'b1;
        PRED_TAKEN = 1'b1;
        run(ei(0, scbu_pkg::COND_GT, 16'h0020), 1, 1, 1, 32'h1020);
        run(ei(0, scbu_pkg::COND_GT, 16'h0020), 0, 3, 0, 32'h1004);
        k = 4;
        while (a2_done !== 1'b1 && k < 20) begin
            @(negedge CORE_CLK);
            k++;
        end
        chk(32'(k), 32'(scbu_pkg::LAT_MISP_DEF));
        run(er(0, scbu_pkg::COND_LT), 0, 1, 0, 32'h1004);
        PRED_TAKEN = 1'b0;
        run(er(0, scbu_pkg::COND_LT), -1, 3, 1, 32'h1200);
        PRED_VALID = 1'b0;
    endtask
    task automatic t_evt;
        slot_wait = 4'h4;
        INTR_REQ = 1'b1;
        BRK_REQ = 1'b1;
        run(er(1, scbu_pkg::COND_LT), -1, 2, 1, 32'h1200);
        chk(INTR_ACK, 1'b0);
        chk(BRK_ACK, 1'b0);
        repeat (8) @(negedge CORE_CLK);
        chk(INTR_ACK, 1'b1);
        chk(BRK_ACK, 1'b1);
        INTR_REQ = 1'b0;
        BRK_REQ = 1'b0;
    endtask
    task automatic results;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        RST = 1'b1;
        {INSTR_VALID, IMM_PREFIX_VALID, PRED_VALID} = 3'h0;
        {PRED_TAKEN, INTR_REQ, BRK_REQ} = 3'h0;
        {INSTR, SOURCE_REG_A} = 64'h0;
        PC_CUR = 32'h0000_1000;
        OFFSET_REG_B = 32'h0000_0200;
        IMM_PREFIX_HI = 16'h1234;
        slot_wait = 4'h0;
        repeat (5) @(negedge CORE_CLK);
        chk(READY, 1'b0);
        chk(NEXT_PC, 32'h0);
        RST = 1'b0;
        repeat (2) @(negedge CORE_CLK);
        t_cond;
        t_slot;
        t_pred;
        t_evt;
        results;
    end
    initial begin
        #1_000_000;
        errors++;
        results;
    end
endmodule
bind scbu_branch_unit scbu_branch_unit_sva u_sva (.*);
`default_nettype wire
